/* File: acr_consts.vh */
// constants for the converter control and parallel readout block
// assumes inclusion by bare name from the design files
`ifndef ACR_CONSTS_VH
`define ACR_CONSTS_VH
`define ACR_CONV_TIME_NS    4000
`define ACR_CLK_PERIOD_NS   5
`define ACR_NUM_CH          8
`define ACR_RES_BITS        18
`define ACR_BUS_BITS        16
`define ACR_HI_LSB          2
`define ACR_WORDS           16
`define ACR_PD_RUN          2'h0
`define ACR_PD_STANDBY      2'h1
`define ACR_PD_SHUTDOWN     2'h2
`endif

/* File: acr_conv_ctrl.v */
// conversion control and parallel readout of an eight-channel converter
// assumes all pins synchronous to clk; analog core supplies results as a bus
//
// Behaviour
// - low power request low: standby or shutdown by span
// - common start edge holds all channels together
// - busy rises on start, falls after conversion
// - conversion of all channels takes 4 us
// - busy fall: back to tracking, results published unless low power request is low at that edge
// - split starts hold channels 1-4 and 5-8
// - conversion starts after both split start edges
// - all eight channels always converted and read
// - interface select low chooses parallel port
// - bus driven only while select and strobe low
// - select rise releases bus, fall enables it
// - busy reads return previous results
// - two strobes per channel result
// - first strobe high bits, second low bits
// - sixteen strobes step channels ascending
// - tied select and strobe: sixteen pulses
// - results in two's complement
`timescale 1ns/1ps
`include "acr_consts.vh"
module acr_conv_ctrl #(
  parameter NUM_CH    = `ACR_NUM_CH,
  parameter RES_BITS  = `ACR_RES_BITS,
  parameter BUS_BITS  = `ACR_BUS_BITS,
  parameter CONV_NS   = `ACR_CONV_TIME_NS,
  parameter CLK_NS    = `ACR_CLK_PERIOD_NS
)(
  input  wire                       clk,
  input  wire                       srst,
  input  wire                       sample_start_a,
  input  wire                       sample_start_b,
  input  wire                       low_power_request_n,
  input  wire                       input_span,
  input  wire                       interface_select,
  input  wire                       chip_select_n,
  input  wire                       read_strobe_n,
  input  wire [NUM_CH*RES_BITS-1:0] core_results,
  output reg                        busy,
  output reg                        hold_set_a,
  output reg                        hold_set_b,
  output reg                        standby,
  output reg                        shutdown,
  output reg                        parallel_sel,
  output reg  [BUS_BITS-1:0]        parallel_bus_out,
  output reg                        parallel_bus_oe
);
  // conversion length in cycles, longest time so rounded down
  localparam integer CONV_CYC_RAW = CONV_NS / CLK_NS;
  localparam integer CONV_CYC     = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_CONV = 2'h2;

  function rise;
    input now_v;
    input prev_v;
    begin
      rise = now_v & ~prev_v;
    end
  endfunction

  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [15:0] cnt_ff;
  reg  [15:0] nxt_cnt;
  reg         sa_prev_ff;
  reg         sb_prev_ff;
  reg         rd_prev_ff;
  reg  [3:0]  word_ff;
  reg         load_ff;
  wire        up_a;
  wire        up_b;
  wire        rd_fall;
  wire        running;
  wire [RES_BITS-1:0] ch_data;

  assign running = low_power_request_n;
  assign up_a    = rise(sample_start_a, sa_prev_ff);
  assign up_b    = rise(sample_start_b, sb_prev_ff);
  assign rd_fall = rise(~read_strobe_n, ~rd_prev_ff) & ~chip_select_n & ~interface_select;

  ////////////////////////////////////////////////////////////////
  // result store
  acr_result_store #(
    .NUM_CH   (NUM_CH),
    .RES_BITS (RES_BITS)
  ) u_store (
    .clk        (clk),
    .srst       (srst),
    .load       (load_ff),
    .results_in (core_results),
    .rd_ch      (word_ff[3:1]),
    .rd_data    (ch_data)
  );

  ////////////////////////////////////////////////////////////////
  // conversion sequencing
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (running && (hold_set_a || up_a) && (hold_set_b || up_b))
        begin
          nxt_state = ST_CONV;
          nxt_cnt   = 16'h0000;
        end
        else if (running && (up_a || up_b))
          nxt_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if ((hold_set_a || up_a) && (hold_set_b || up_b))
        begin
          nxt_state = ST_CONV;
          nxt_cnt   = 16'h0000;
        end
      end
      ST_CONV:
      begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (cnt_ff == CONV_CYC[15:0] - 16'h0001)
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
    if (!running)
      nxt_state = ST_IDLE;
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      state_ff   <= ST_IDLE;
      cnt_ff     <= 16'h0000;
      sa_prev_ff <= 1'b0;
      sb_prev_ff <= 1'b0;
      busy       <= 1'b0;
      hold_set_a <= 1'b0;
      hold_set_b <= 1'b0;
      load_ff    <= 1'b0;
      standby    <= 1'b0;
      shutdown   <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      sa_prev_ff <= sample_start_a;
      sb_prev_ff <= sample_start_b;
      busy       <= (nxt_state == ST_CONV);
      // all conversions end, sample stages return to tracking
      if (state_ff == ST_CONV && nxt_state != ST_CONV)
      begin
        hold_set_a <= 1'b0;
        hold_set_b <= 1'b0;
      end
      else
      begin
        if (running && up_a && state_ff != ST_CONV)
          hold_set_a <= 1'b1;
        if (running && up_b && state_ff != ST_CONV)
          hold_set_b <= 1'b1;
        if (!running)
        begin
          hold_set_a <= 1'b0;
          hold_set_b <= 1'b0;
        end
      end
      load_ff  <= (state_ff == ST_CONV && nxt_state == ST_IDLE && running);
      standby  <= ~low_power_request_n & input_span;
      shutdown <= ~low_power_request_n & ~input_span;
    end
  end

  ////////////////////////////////////////////////////////////////
  // parallel readout
  always @(posedge clk)
  begin
    if (srst)
    begin
      rd_prev_ff       <= 1'b1;
      word_ff          <= 4'h0;
      parallel_sel     <= 1'b1;
      parallel_bus_out <= {BUS_BITS{1'b0}};
      parallel_bus_oe  <= 1'b0;
    end
    else
    begin
      rd_prev_ff   <= read_strobe_n;
      parallel_sel <= ~interface_select;
      parallel_bus_oe <= ~interface_select & ~chip_select_n & ~read_strobe_n;
      // a strobe fall on the load edge is dropped; the host keeps clear of it
      if (load_ff)
        word_ff <= 4'h0;                        // next fall starts channel 1
      else if (rd_fall)
      begin
        word_ff <= word_ff + 4'h1;
        if (!word_ff[0])
          parallel_bus_out <= ch_data[RES_BITS-1:`ACR_HI_LSB];
        else
          parallel_bus_out <= {{(BUS_BITS-`ACR_HI_LSB){1'b0}},
                               ch_data[`ACR_HI_LSB-1:0]};
      end
    end
  end
  // word_ff upper bits pick the channel, bit 0 picks high or low half;
  // even words carry the high bits, odd words the two low bits

endmodule // acr_conv_ctrl

/* File: acr_conv_ctrl_asserts.sv */
// assertions on the ports of the conversion control block
// assumes one clk domain with synchronous active-high srst
`timescale 1ns/1ps
module acr_conv_ctrl_asserts #(
  parameter NUM_CH   = 8,
  parameter RES_BITS = 18,
  parameter BUS_BITS = 16,
  parameter CONV_NS  = 4000,
  parameter CLK_NS   = 5
)(
  input wire                       clk,
  input wire                       srst,
  input wire                       sample_start_a,
  input wire                       sample_start_b,
  input wire                       low_power_request_n,
  input wire                       input_span,
  input wire                       interface_select,
  input wire                       chip_select_n,
  input wire                       read_strobe_n,
  input wire [NUM_CH*RES_BITS-1:0] core_results,
  input wire                       busy,
  input wire                       hold_set_a,
  input wire                       hold_set_b,
  input wire                       standby,
  input wire                       shutdown,
  input wire                       parallel_sel,
  input wire [BUS_BITS-1:0]        parallel_bus_out,
  input wire                       parallel_bus_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [15:0] busy_cnt_ff;
  always @(posedge clk) busy_cnt_ff <= (srst || !busy) ? 16'h0 : busy_cnt_ff + 16'h1;
  sequence s_rd_on; !chip_select_n && !read_strobe_n && !interface_select; endsequence
  sequence s_run; !busy && low_power_request_n; endsequence
  property p_standby; !low_power_request_n && input_span |-> ##[1:2] standby; endproperty
  a_standby: assert property (p_standby) else $error("standby missing");
  property p_shutdown; !low_power_request_n && !input_span |-> ##[1:2] shutdown; endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown missing");
  property p_hold_a; $rose(sample_start_a) ##0 s_run |=> hold_set_a; endproperty
  a_hold_a: assert property (p_hold_a) else $error("hold a late");
  property p_hold_b; $rose(sample_start_b) ##0 s_run |=> hold_set_b; endproperty
  a_hold_b: assert property (p_hold_b) else $error("hold b late");
  property p_busy_rise; $rose(busy) |-> hold_set_a && hold_set_b && ($past(sample_start_a)
    && !$past(sample_start_a, 2) || $past(sample_start_b) && !$past(sample_start_b, 2)); endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy rise wrong");
  property p_busy_len; $fell(busy) && low_power_request_n |-> busy_cnt_ff == CONV_NS / CLK_NS; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_track; $fell(busy) |-> !hold_set_a && !hold_set_b; endproperty
  a_track: assert property (p_track) else $error("holds not released");
  property p_oe_on; s_rd_on ##1 s_rd_on |-> parallel_bus_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven");
  property p_oe_off; parallel_bus_oe |-> !$past(chip_select_n) && !$past(read_strobe_n)
    && !$past(interface_select); endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven wrongly");
  property p_cs_rise; $rose(chip_select_n) |=> !parallel_bus_oe; endproperty
  a_cs_rise: assert property (p_cs_rise) else $error("bus not released");
  property p_sel; $stable(interface_select) |-> parallel_sel == !interface_select; endproperty
  a_sel: assert property (p_sel) else $error("port select wrong");
endmodule // acr_conv_ctrl_asserts
bind acr_conv_ctrl acr_conv_ctrl_asserts #(.NUM_CH(NUM_CH), .RES_BITS(RES_BITS), .BUS_BITS(BUS_BITS),
  .CONV_NS(CONV_NS), .CLK_NS(CLK_NS)) u_chk (.*);

/* File: acr_host_model.sv */
// host model: drives the start pins and the parallel read strobes
// assumes the converter's clk; idle start lines rest low, select and strobe lines high
`timescale 1ns/1ps
module acr_host_model (
  input  wire  clk,
  output logic sample_start_a,
  output logic sample_start_b,
  output logic chip_select_n,
  output logic read_strobe_n
);
  initial {sample_start_a, sample_start_b, chip_select_n, read_strobe_n} = 4'h3;
  // gap above zero raises a first, below zero raises b first
  task start(input int gap);
    @(posedge clk) #1 sample_start_a = (gap >= 0);
    sample_start_b = (gap <= 0);
    if (gap != 0)
    begin
      repeat ((gap < 0) ? -gap : gap) @(posedge clk);
      #1 {sample_start_a, sample_start_b} = 2'h3;
    end
    repeat (2) @(posedge clk);
    #1 {sample_start_a, sample_start_b} = 2'h0;
  endtask
  // one strobe pulse; tied raises select with the strobe
  task rd(input bit tied);
    @(posedge clk) #1 chip_select_n = 0;
    read_strobe_n = 0;
    repeat (3) @(posedge clk);
    #1 read_strobe_n = 1;
    chip_select_n = tied;
    @(posedge clk) #1;
  endtask
  task idle;
    @(posedge clk) #1 chip_select_n = 1;
  endtask
endmodule // acr_host_model

/* File: acr_result_store.v */
// result store: eight 18-bit results, loaded together at end of conversion
// assumes results arrive from the converter core in two's complement
`timescale 1ns/1ps
`include "acr_consts.vh"
module acr_result_store #(
  parameter NUM_CH   = `ACR_NUM_CH,
  parameter RES_BITS = `ACR_RES_BITS
)(
  input  wire                       clk,
  input  wire                       srst,
  input  wire                       load,
  input  wire [NUM_CH*RES_BITS-1:0] results_in,
  input  wire [2:0]                 rd_ch,
  output wire [RES_BITS-1:0]        rd_data
);
  reg [RES_BITS-1:0] mem_ff [0:NUM_CH-1];
  integer i;

  // all channels are updated at one instant, never partially
  always @(posedge clk)
  begin
    for (i = 0; i < NUM_CH; i = i + 1)
    begin
      if (srst)
        mem_ff[i] <= {RES_BITS{1'b0}};
      else if (load)
        mem_ff[i] <= results_in[i*RES_BITS +: RES_BITS];
    end
  end

  assign rd_data = mem_ff[rd_ch];
endmodule // acr_result_store

/* File: tb_acr_conv_ctrl.sv */
// self-checking bench for the conversion control block
// assumes the host model and checker are compiled first
`timescale 1ns/1ps
module tb_acr_conv_ctrl;
  logic clk, srst, sample_start_a, sample_start_b, low_power_request_n, input_span;
  logic interface_select, chip_select_n, read_strobe_n, busy, hold_set_a, hold_set_b;
  logic standby, shutdown, parallel_sel, parallel_bus_oe, last_oe;
  logic [15:0] parallel_bus_out;
  logic [143:0] core_results, prev_res;
  logic [15:0] exp_q[$];
  int num_errors = 0;
  int comparisons = 0;
  acr_conv_ctrl #(.CONV_NS(150)) uut (.*);
  acr_host_model h (.*);
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #20000 num_errors++;
    results();
  end
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task results;
    if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // queue w words: high bits then two low bits per channel
  task push(input logic [143:0] r, input int w);
    for (int i = 0; i < w; i++) exp_q.push_back(i[0] ? {14'h0, r[i/2*18+:2]} : r[i/2*18+2+:16]);
  endtask
  always @(negedge clk)
  begin
    last_oe <= parallel_bus_oe;
    if (last_oe === 1'b1 && parallel_bus_oe === 1'b0)
      chk("parallel_bus", parallel_bus_out, exp_q.size() ? exp_q.pop_front() : ~parallel_bus_out);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task conv(input int gap, input bit tied, input int early);
    prev_res = core_results;
    for (int i = 0; i < 8; i++) core_results[i*18+:18] = 18'($urandom);
    h.start(gap);
    push(prev_res, early);
    repeat (early) h.rd(1);
    for (int i = 0; i < 100 && busy; i++) @(negedge clk);
    chk("busy_end", {15'h0, busy}, 16'h0);
    repeat (3) @(posedge clk);
    push(core_results, 16);
    repeat (16) h.rd(tied);
    h.idle();
  endtask
  initial
  begin
    void'($urandom(12));
    {srst, low_power_request_n, input_span, interface_select} = 4'hE;
    core_results = '0;
    repeat (2) @(posedge clk);
    #1 srst = 0;
    chk("reset", {14'h0, parallel_sel, busy}, 16'h2);
    conv(0, 0, 0);
    conv(4, 1, 2);
    low_power_request_n = 0;
    repeat (3) @(posedge clk);
    #1 chk("standby", {14'h0, standby, shutdown}, 16'h2);
    h.start(0);
    chk("busy", {15'h0, busy}, 16'h0);
    input_span = 0;
    repeat (3) @(posedge clk);
    #1 chk("shutdown", {14'h0, standby, shutdown}, 16'h1);
    low_power_request_n = 1;
    repeat (20) @(posedge clk);
    #1 srst = 1;
    repeat (2) @(posedge clk);
    #1 {srst, interface_select, input_span} = 3'h3;
    h.rd(1);
    chk("serial_port", {15'h0, parallel_sel}, 16'h0);
    interface_select = 0;
    conv(-2, 0, 0);
    chk("words_left", 16'(exp_q.size()), 16'h0);
    results();
  end
endmodule // tb_acr_conv_ctrl
